// ---- hw/pdc_pkg.sv ----
// Package: register map, field layout, reset values and serial command coding
`default_nettype none
package pdc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [5:0] PDC_CTRL_ADDR = 6'h03; // pad_drive_clock_out_ctrl
  // ==========================================================================
  // Field positions inside pad_drive_clock_out_ctrl
  localparam int PDC_PAD_DRV_LSB = 6;   // Bits 7:6, general output drive
  localparam int PDC_CLK_DRV_LSB = 4;   // Bits 5:4, clock output drive
  localparam int PDC_SHA_BIT = 3;       // Bit 3, clock output shadow select
  localparam int PDC_RATE_LSB = 0;      // Bits 2:0, clock output rate
  // ==========================================================================
  // Reset values
  localparam logic [1:0] PDC_PAD_DRV_RST = 2'h0;  // 2 mA
  localparam logic [1:0] PDC_CLK_DRV_RST = 2'h1;  // 4 mA
  localparam logic PDC_SHA_RST = 1'b1;
  localparam logic [2:0] PDC_RATE_RST = 3'h1;
  localparam logic [7:0] PDC_CTRL_RST = 8'h19;
  // ==========================================================================
  // Drive current codes, shared by both drive fields
  localparam logic [1:0] PDC_DRV_2MA = 2'h0;
  localparam logic [1:0] PDC_DRV_4MA = 2'h1;
  localparam logic [1:0] PDC_DRV_6MA = 2'h2;
  localparam logic [1:0] PDC_DRV_8MA = 2'h3;
  // ==========================================================================
  // Serial command byte: bit 7 marks register access, bit 6 marks a write
  localparam int PDC_CMD_REG_BIT = 7;
  localparam int PDC_CMD_WR_BIT = 6;
  // ==========================================================================
  // Serial frame bit counts
  localparam logic [4:0] PDC_CMD_LAST = 5'h07;   // Last command bit index
  localparam logic [4:0] PDC_DATA_FIRST = 5'h08; // First data bit index
  localparam logic [4:0] PDC_DATA_LAST = 5'h0f;  // Last data bit index
  localparam logic [4:0] PDC_FRAME_DONE = 5'h10; // Frame complete
endpackage : pdc_pkg
`default_nettype wire

// ---- hw/pdc_top.sv ----
// Pad drive and pull control with serial access to its control register
// Function
// - Bits 7:6 select general output drive 2/4/6/8 mA, reset 2 mA.
// - Bits 5:4 select clock output drive 2/4/6/8 mA, reset 4 mA.
// - In power-on state, weak pulls connect: up on reset/select, down on rest.
// - In all other states, in reset or not, all input pulls disconnect.
// - Auxiliary outputs not enabled are held low.
// - Register 0x03 also holds shadow select bit 3 and rate field 2:0.
// - Control register contents survive sleep untouched.
`default_nettype none
module pdc_top (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic SPI_SEL_N_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_MOSI_IN,
  input wire logic PON_STATE_IN,
  input wire logic [3:0] AUX_EN_IN,
  input wire logic [3:0] AUX_DATA_IN,
  output logic SPI_MISO_OUT,
  output logic [1:0] PAD_DRIVE_SEL_OUT,
  output logic [1:0] CLK_OUT_DRIVE_SEL_OUT,
  output logic CLK_OUT_SHADOW_SEL_OUT,
  output logic [2:0] CLK_OUT_RATE_SEL_OUT,
  output logic [1:0] PULL_UP_EN_OUT,
  output logic [2:0] PULL_DOWN_EN_OUT,
  output logic [3:0] AUX_OUT,
  output logic [3:0] AUX_PULL_DOWN_OUT
);

  // ==========================================================================
  // Address decode, shared by the read and write paths
  function automatic logic pdc_hit(input logic [7:0] cmd);
    pdc_hit = cmd[pdc_pkg::PDC_CMD_REG_BIT] &&
              (cmd[5:0] == pdc_pkg::PDC_CTRL_ADDR);
  endfunction

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_d_reg;
  logic sel_n_s;
  logic sclk_s;
  logic mosi_s;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_shift_reg;
  logic miso_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic wr_fire;
  logic [7:0] rd_data;

  // ==========================================================================
  // Pin synchronisers; first stage feeds only the second
  // Reset to the idle pin levels (select high, clock and data low) so
  // that no false serial clock edge is seen just after reset
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
      sclk_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {SPI_SEL_N_IN, SPI_SCLK_IN, SPI_MOSI_IN};
      sync2_reg <= sync1_reg;
      sclk_d_reg <= sync2_reg[1];
    end
  end

  assign sel_n_s = sync2_reg[2];
  assign sclk_s = sync2_reg[1];
  assign mosi_s = sync2_reg[0];
  assign sclk_rise = sclk_s && !sclk_d_reg && !sel_n_s;
  assign sclk_fall = !sclk_s && sclk_d_reg && !sel_n_s;

  // ==========================================================================
  // Receive side: bit counter, shifter and command capture
  // Extra bits after the data byte are ignored until select rises again
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN || sel_n_s) begin
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 8'h00;
      cmd_reg <= 8'h00;
    end else if (sclk_rise && bit_cnt_reg != pdc_pkg::PDC_FRAME_DONE) begin
      shift_in_reg <= {shift_in_reg[6:0], mosi_s};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == pdc_pkg::PDC_CMD_LAST) begin
        cmd_reg <= {shift_in_reg[6:0], mosi_s};
      end
    end
  end

  // Write lands on the last data bit only for a write to our address
  assign wr_fire = sclk_rise && (bit_cnt_reg == pdc_pkg::PDC_DATA_LAST) &&
                   cmd_reg[pdc_pkg::PDC_CMD_WR_BIT] && pdc_hit(cmd_reg);
  assign ctrl_next = {shift_in_reg[6:0], mosi_s};

  // ==========================================================================
  // Control register; no sleep input reaches it, so contents persist
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      ctrl_reg <= pdc_pkg::PDC_CTRL_RST;
    end else if (wr_fire) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================================
  // Read side: unmapped or write frames return zero on the data byte
  assign rd_data = (pdc_hit(cmd_reg) && !cmd_reg[pdc_pkg::PDC_CMD_WR_BIT]) ?
                   ctrl_reg : 8'h00;

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN || sel_n_s) begin
      tx_shift_reg <= 8'h00;
      miso_reg <= 1'b0;
    end else if (sclk_fall && bit_cnt_reg == pdc_pkg::PDC_DATA_FIRST) begin
      tx_shift_reg <= {rd_data[6:0], 1'b0};
      miso_reg <= rd_data[7];
    end else if (sclk_fall && bit_cnt_reg > pdc_pkg::PDC_DATA_FIRST &&
                 bit_cnt_reg <= pdc_pkg::PDC_DATA_LAST) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      miso_reg <= tx_shift_reg[7];
    end
  end

  assign SPI_MISO_OUT = miso_reg;

  // ==========================================================================
  // Field outputs to the pad drivers and clock output logic
  // Software should keep clock drive at 2 mA when it can
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      PAD_DRIVE_SEL_OUT <= pdc_pkg::PDC_PAD_DRV_RST;
      CLK_OUT_DRIVE_SEL_OUT <= pdc_pkg::PDC_CLK_DRV_RST;
      CLK_OUT_SHADOW_SEL_OUT <= pdc_pkg::PDC_SHA_RST;
      CLK_OUT_RATE_SEL_OUT <= pdc_pkg::PDC_RATE_RST;
    end else begin
      PAD_DRIVE_SEL_OUT <= ctrl_reg[pdc_pkg::PDC_PAD_DRV_LSB +: 2];
      CLK_OUT_DRIVE_SEL_OUT <= ctrl_reg[pdc_pkg::PDC_CLK_DRV_LSB +: 2];
      CLK_OUT_SHADOW_SEL_OUT <= ctrl_reg[pdc_pkg::PDC_SHA_BIT];
      CLK_OUT_RATE_SEL_OUT <= ctrl_reg[pdc_pkg::PDC_RATE_LSB +: 3];
    end
  end

  // ==========================================================================
  // Input pulls follow the power-on state, reset or not
  // Reset does not clear them: a reset during power-on keeps pulls on
  always_ff @(posedge REF_CLK_IN) begin
    if (PON_STATE_IN) begin
      PULL_UP_EN_OUT <= 2'h3;
      PULL_DOWN_EN_OUT <= 3'h7;
    end else begin
      PULL_UP_EN_OUT <= 2'h0;
      PULL_DOWN_EN_OUT <= 3'h0;
    end
  end

  // ==========================================================================
  // Auxiliary outputs: low and pulled down unless enabled
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      AUX_OUT <= 4'h0;
      AUX_PULL_DOWN_OUT <= 4'hf;
    end else begin
      AUX_OUT <= AUX_EN_IN & AUX_DATA_IN;
      AUX_PULL_DOWN_OUT <= ~AUX_EN_IN;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking pdc_cb @(posedge REF_CLK_IN); endclocking

  drive_reset_a: assert property (
    RST_IN |=> ##1 PAD_DRIVE_SEL_OUT == pdc_pkg::PDC_DRV_2MA)
    else $error("General drive not 2 mA after reset");
  clk_drive_reset_a: assert property (
    RST_IN |=> ##1 CLK_OUT_DRIVE_SEL_OUT == pdc_pkg::PDC_DRV_4MA)
    else $error("Clock drive not 4 mA after reset");
  clk_fields_reset_a: assert property (
    RST_IN |=> ##1 CLK_OUT_SHADOW_SEL_OUT && CLK_OUT_RATE_SEL_OUT == 3'h1)
    else $error("Clock output fields wrong after reset");
  pull_on_a: assert property (
    PON_STATE_IN |=> PULL_UP_EN_OUT == 2'h3 && PULL_DOWN_EN_OUT == 3'h7)
    else $error("Pulls not connected in power-on");
  pull_off_a: assert property (
    !PON_STATE_IN |=> PULL_UP_EN_OUT == 2'h0 && PULL_DOWN_EN_OUT == 3'h0)
    else $error("Pulls left connected outside power-on");
  aux_low_a: assert property (disable iff (RST_IN)
    1'b1 |=> (AUX_OUT & ~$past(AUX_EN_IN)) == 4'h0)
    else $error("Disabled auxiliary output not low");
  hold_value_a: assert property (disable iff (RST_IN)
    !wr_fire |=> $stable(ctrl_reg))
    else $error("Control register changed without a write");
  write_take_a: assert property (disable iff (RST_IN)
    wr_fire |=> ctrl_reg == $past(ctrl_next) ##1
      PAD_DRIVE_SEL_OUT == ctrl_reg[7:6])
    else $error("Written value not taken or not driven");
  readback_a: assert property (disable iff (RST_IN)
    sclk_fall && bit_cnt_reg == pdc_pkg::PDC_DATA_FIRST &&
    pdc_hit(cmd_reg) && !cmd_reg[pdc_pkg::PDC_CMD_WR_BIT]
    |=> SPI_MISO_OUT == $past(ctrl_reg[7]))
    else $error("Read data first bit wrong");
  miso_idle_a: assert property (disable iff (RST_IN)
    sel_n_s |=> !SPI_MISO_OUT)
    else $error("Serial data out not low while deselected");

  write_seen_c: cover property (disable iff (RST_IN) wr_fire);
  read_seen_c: cover property (disable iff (RST_IN)
    sclk_fall && bit_cnt_reg == pdc_pkg::PDC_DATA_FIRST &&
    pdc_hit(cmd_reg) && !cmd_reg[pdc_pkg::PDC_CMD_WR_BIT]);
  pon_leave_c: cover property (PON_STATE_IN ##1 !PON_STATE_IN);
  // A frame cut short after twelve bits must end without a write
  abort_seen_c: cover property (disable iff (RST_IN)
    !sel_n_s && bit_cnt_reg == 5'h0c ##1 sel_n_s);

endmodule // pdc_top
`default_nettype wire

// ---- test/pdc_host_model.sv ----
// Microcontroller model: serial master that frames register accesses
`default_nettype none
module pdc_host_model (
  input wire logic REF_CLK_IN,
  input wire logic SPI_MISO_IN,
  output logic SPI_SEL_N_OUT,
  output logic SPI_SCLK_OUT,
  output logic SPI_MOSI_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Serial master
  // Idle: select high, serial clock parked low between frames
  initial begin
    SPI_SEL_N_OUT = 1'b1;
    SPI_SCLK_OUT = 1'b0;
    SPI_MOSI_OUT = 1'b0;
  end
  // Five cycles per phase, since the block needs three to act on an edge
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [7:0] rdata);
    rdata = 8'h00;
    @(posedge REF_CLK_IN);
    SPI_SEL_N_OUT <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      SPI_SCLK_OUT <= 1'b0;
      SPI_MOSI_OUT <= word[i]; // Always a defined level
      repeat (5) @(posedge REF_CLK_IN);
      if (i < 8) rdata[i] = SPI_MISO_IN; // Taken just before the rise
      SPI_SCLK_OUT <= 1'b1;
      repeat (5) @(posedge REF_CLK_IN);
    end
    SPI_SCLK_OUT <= 1'b0;
    repeat (5) @(posedge REF_CLK_IN);
    SPI_SEL_N_OUT <= 1'b1;
    SPI_MOSI_OUT <= ~SPI_MOSI_OUT; // Data line flipped from its last bit: no stale value
    repeat (6) @(posedge REF_CLK_IN);
  endtask
endmodule // pdc_host_model
`default_nettype wire

// ---- test/pad_drive_pull_control_test.sv ----
// Self-checking bench for the pad drive and pull control block
`default_nettype none
module pad_drive_pull_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, pon = 1'b1, sel_n, sclk, mosi, miso, sha;
  logic [3:0] aux_en = 4'h0, aux_dat = 4'h0, aux, aux_pd;
  logic [1:0] pad_drv, clk_drv, pu;
  logic [2:0] rate, pd;
  logic [7:0] rd, cur;
  int num_errors = 0, tests_run = 0, cycles = 0;
  // ==========================================================================
  // Clock, hang guard and instances
  always #12.5 clk = ~clk;
  // Ceiling far above the few thousand cycles the sequence takes
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  pdc_top u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .SPI_SEL_N_IN(sel_n),
    .SPI_SCLK_IN(sclk), .SPI_MOSI_IN(mosi), .PON_STATE_IN(pon),
    .AUX_EN_IN(aux_en), .AUX_DATA_IN(aux_dat), .SPI_MISO_OUT(miso),
    .PAD_DRIVE_SEL_OUT(pad_drv), .CLK_OUT_DRIVE_SEL_OUT(clk_drv),
    .CLK_OUT_SHADOW_SEL_OUT(sha), .CLK_OUT_RATE_SEL_OUT(rate),
    .PULL_UP_EN_OUT(pu), .PULL_DOWN_EN_OUT(pd), .AUX_OUT(aux),
    .AUX_PULL_DOWN_OUT(aux_pd));
  pdc_host_model u_host (.REF_CLK_IN(clk), .SPI_MISO_IN(miso),
    .SPI_SEL_N_OUT(sel_n), .SPI_SCLK_OUT(sclk), .SPI_MOSI_OUT(mosi));
  // ==========================================================================
  // Shared tasks
  // Outputs are read at the edge, so registered values are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string name, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    u_host.xfer({2'b11, a, v}, 16, rd);
  endtask
  // Field outputs and a serial read must all agree with one value
  task automatic chk_reg(input logic [7:0] v);
    cyc(2);
    chk("pad drive", {6'h00, v[7:6]}, {6'h00, pad_drv});
    chk("clock drive", {6'h00, v[5:4]}, {6'h00, clk_drv});
    chk("shadow rate", {4'h0, v[3:0]}, {4'h0, sha, rate});
    u_host.xfer(16'h8300, 16, rd);
    chk("readback", v, rd);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // Every drive code in both fields, back to back
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      cur = {c[1:0], 2'(3 - c), c[0], c[1], ~c[0], 1'b1};
      wr(6'h03, cur);
      chk_reg(cur);
    end
  endtask
  // Unmapped, non-register and cut-short frames leave the register alone
  task automatic t_refused;
    wr(6'h04, 8'hff);
    u_host.xfer(16'h8400, 16, rd);
    chk("unmapped read", 8'h00, rd);
    u_host.xfer(16'h43ff, 16, rd);
    u_host.xfer(16'hc3ff, 12, rd);
    chk_reg(cur);
  endtask
  // Disabled aux outputs pulled low, enabled ones follow data
  task automatic t_aux;
    aux_en <= 4'h5;
    aux_dat <= 4'hf;
    cyc(2);
    chk("aux out", 8'h05, {4'h0, aux});
    chk("aux pull", 8'h0a, {4'h0, aux_pd});
    aux_en <= 4'ha;
    aux_dat <= 4'h3;
    cyc(2);
    chk("aux out", 8'h02, {4'h0, aux});
    chk("aux pull", 8'h05, {4'h0, aux_pd});
    chk_reg(cur);
  endtask
  // Pulls in power-on, also under reset; none elsewhere, reset too
  task automatic t_pull;
    pon <= 1'b0;
    cyc(2);
    chk("pulls", 8'h00, {3'h0, pu, pd});
    pon <= 1'b1;
    rst <= 1'b1;
    cyc(3);
    chk("pulls", 8'h1f, {3'h0, pu, pd});
    pon <= 1'b0;
    cyc(2);
    chk("pulls", 8'h00, {3'h0, pu, pd});
    rst <= 1'b0;
    chk_reg(8'h19);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    cyc(6);
    rst <= 1'b0; // Chip reset held six cycles, then released
    chk("pulls", 8'h1f, {3'h0, pu, pd});
    chk("aux pull", 8'h0f, {4'h0, aux_pd});
    chk_reg(8'h19);
    t_codes();
    t_refused();
    t_aux();
    t_pull();
    wr(6'h03, 8'h09);
    chk_reg(8'h09);
    complete_run();
  end
endmodule // pad_drive_pull_control_test
`default_nettype wire
